// file: test/tb_top.sv
// self-checking bench for the weld control input decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 0, srst = 1, jmp = 0, pbf = 0, mpf = 0, rdy = 0, tk = 0, swr = 0;
   logic [8:0] cl = '0;
   logic [2:0] r, v, q[$];
   wire [8:0] pn;
   wire [2:0] ss, ps;
   wire [3:0] sf;
   wire os, oa, sq, ew, td, hp, me, te, we, pl;
   int err_total = 0, num_checks = 0, seed = 32'h076488ea;
   always #25 clk = ~clk;
   wcid_contact #(.N(9)) far (.clk(clk), .closed(cl), .pin_n(pn));
   wcid_decoder #(.DEBOUNCE_CYC(17'h4)) dut (.clk(clk), .srst(srst), .iso_operate_n(pn[0]),
      .switch_operate_request_n(pn[1]), .auto_stop_n(pn[2]), .press_control_n(pn[3]),
      .hand_probe_present_n(pn[4]), .setup_select_n(pn[7:5]), .panel_lock_n(pn[8]),
      .stop_meaning_jumper(jmp), .press_board_fitted(pbf), .multi_probe_controller_fitted(mpf),
      .probe_selector_ready(rdy), .test_key(tk), .settings_write_req(swr), .operate_start(os),
      .operate_active(oa), .sequence_stop(sq), .end_of_weld(ew), .thruster_down(td),
      .hand_probe_present(hp), .setup_select(ss), .setup_file(sf), .probe_select(ps),
      .multi_probe_controller_en(me), .test_key_en(te), .settings_write_en(we), .panel_locked(pl));
   task check(input logic [3:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task print_verdict;
      if (q.size() != 0) begin
         err_total++;
         $display("mismatch at %0t: expected pulses never seen", $time);
      end
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task put(input int b, input logic x);
      cl[b] <= x;
      repeat (12) @(posedge clk);
   endtask
   // pulses are matched in order against the notes left by the driver
   always @(posedge clk) if (!srst && (os || sq || ew)) begin
      if (q.size() == 0) check(4'hF, 4'h0);
      else check({os, sq, ew}, q.pop_front());
   end
   initial begin
      repeat (5) @(posedge clk);
      srst <= 0;
      @(posedge clk);
      check(sf, 4'h1);
      r = $random(seed);
      mpf <= 1;
      rdy <= 1;
      for (int i = 0; i < 8; i++) begin
         v = i[2:0] ^ r;
         cl[7:6] <= v[2:1];
         put(5, v[0]);
         check(sf, {1'b0, v} + 4'h1);
         check({1'b0, ss}, {1'b0, v});
         check(ps, v);
      end
      rdy <= 0;
      cl[7:6] <= ~v[2:1];
      put(5, ~v[0]);
      check(ps, v);
      for (int j = 0; j < 2; j++) begin
         q.push_back(3'b100);
         put(j, 1);
         check(oa, 1);
         put(j, 0);
         check(oa, 0);
      end
      for (int k = 0; k < 2; k++) begin
         jmp <= k[0];
         q.push_back(3'b100);
         put(0, 1);
         q.push_back(k ? 3'b001 : 3'b010);
         put(2, 1);
         if (k == 0) check(oa, 0);
         put(2, 0);
         put(0, 0);
      end
      mpf <= 0;
      pbf <= 1;
      put(4, 1);
      put(3, 1);
      check(td, 1);
      check(hp, 1);
      mpf <= 1;
      put(3, 1);
      check({td, me}, 2'b00);
      for (int m = 0; m < 2; m++) begin
         tk <= $random(seed);
         swr <= 1;
         put(8, !m);
         check({pl, te, we}, {!m[0], tk & m[0], m[0]});
      end
      print_verdict();
   end
endmodule // tb_top
`default_nettype wire

// file: test/wcid_checker.sv
// assertion checker for the weld control input decoder
`timescale 1ns/1ps
`default_nettype none
module wcid_checker (
   input wire logic clk, srst, test_key, settings_write_req, panel_locked, test_key_en,
   settings_write_en, thruster_down, multi_probe_controller_en, multi_probe_controller_fitted,
   operate_start, sequence_stop, end_of_weld, stop_meaning_jumper, probe_selector_ready,
   input wire logic [2:0] setup_select, probe_select,
   input wire logic [3:0] setup_file
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   a_file_plus_one: assert property (setup_file == setup_select + 4'h1)
      else $error("bad file");
   a_key_locked: assert property (!$past(srst) && $stable(panel_locked) |->
      test_key_en == ($past(test_key) && !panel_locked)) else $error("bad key");
   a_write_locked: assert property (!$past(srst) && $stable(panel_locked) |->
      settings_write_en == ($past(settings_write_req) && !panel_locked)) else $error("bad write");
   a_options_exclusive: assert property (!(thruster_down && multi_probe_controller_en))
      else $error("both options");
   a_thruster_up: assert property ($past(multi_probe_controller_fitted) |-> !thruster_down)
      else $error("thruster down");
   a_probe_held: assert property (!$past(probe_selector_ready) |-> $stable(probe_select))
      else $error("probe moved");
   a_start_pulse: assert property (operate_start |=> !operate_start)
      else $error("long start");
   a_stop_meaning: assert property (sequence_stop |-> !$past(stop_meaning_jumper))
      else $error("bad stop");
   a_eow_meaning: assert property (end_of_weld |-> $past(stop_meaning_jumper))
      else $error("bad end");
endmodule // wcid_checker
bind wcid_decoder wcid_checker chk (.*);
`default_nettype wire

// file: test/wcid_contact.sv
// contact-closure model of the automation equipment
`timescale 1ns/1ps
`default_nettype none
module wcid_contact #(parameter int N = 9) (
   input wire logic clk,
   input wire logic [N-1:0] closed,
   output logic [N-1:0] pin_n
);
   logic [N-1:0] d1 = '0, d2 = '0;
   initial pin_n = '1;
   // closed pulls low, open floats to the pull-up; each change bounces back one cycle
   always @(posedge clk) begin
      d1 <= closed;
      d2 <= d1;
      pin_n <= ~closed ^ (d1 ^ d2);
   end
endmodule // wcid_contact
`default_nettype wire

// file: verilog/wcid_debounce.v
// synchroniser and debounce filter for one contact-closure input
`timescale 1ns/1ps
`default_nettype none
`include "wcid_map.vh"
module wcid_debounce #(
   parameter [`WCID_CNT_W-1:0] DEBOUNCE_CYC = `WCID_DEBOUNCE_CYC
) (
   input wire clk,
   input wire srst,
   input wire pin_n,
   output reg level
);
   reg sync_a;
   reg sync_b;
   reg [`WCID_CNT_W-1:0] count;
   // grounded pin means asserted, open (pulled high) means idle
   always @(posedge clk) begin
      if (srst) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         count <= {`WCID_CNT_W{1'b0}};
         level <= 1'b0;
      end else begin
         sync_a <= ~pin_n;
         sync_b <= sync_a;
         // level moves only after the new value held a full window
         if (sync_b == level) begin
            count <= {`WCID_CNT_W{1'b0}};
         end else if (count >= DEBOUNCE_CYC - 1'b1) begin
            count <= {`WCID_CNT_W{1'b0}};
            level <= sync_b;
         end else begin
            count <= count + 1'b1;
         end
      end
   end
endmodule // wcid_debounce
`default_nettype wire

// file: verilog/wcid_decoder.v
// decoder of the discrete automation control inputs
`timescale 1ns/1ps
`default_nettype none
`include "wcid_map.vh"
module wcid_decoder #(
   parameter [`WCID_CNT_W-1:0] DEBOUNCE_CYC = `WCID_DEBOUNCE_CYC
) (
   input wire clk,
   input wire srst,
   input wire iso_operate_n,
   input wire switch_operate_request_n,
   input wire auto_stop_n,
   input wire press_control_n,
   input wire hand_probe_present_n,
   input wire [2:0] setup_select_n,
   input wire panel_lock_n,
   input wire stop_meaning_jumper,
   input wire press_board_fitted,
   input wire multi_probe_controller_fitted,
   input wire probe_selector_ready,
   input wire test_key,
   input wire settings_write_req,
   output reg operate_start,
   output reg operate_active,
   output reg sequence_stop,
   output reg end_of_weld,
   output reg thruster_down,
   output reg hand_probe_present,
   output reg [2:0] setup_select,
   output reg [3:0] setup_file,
   output reg [2:0] probe_select,
   output reg multi_probe_controller_en,
   output reg test_key_en,
   output reg settings_write_en,
   output reg panel_locked
);
   wire [`WCID_N_IN-1:0] raw_n;
   wire [`WCID_N_IN-1:0] clean;
   reg operate_prev;
   reg stop_prev;
   wire any_operate;
   wire stop_edge;

   // stop_meaning_jumper: 0 = automation stop, 1 = end of weld
   function [3:0] file_of;
      input [2:0] sel;
      begin
         file_of = {1'b0, sel} + 4'h1;
      end
   endfunction

   assign raw_n = {panel_lock_n, setup_select_n, hand_probe_present_n,
                   press_control_n, auto_stop_n, switch_operate_request_n,
                   iso_operate_n};

   genvar g;
   generate
      for (g = 0; g < `WCID_N_IN; g = g + 1) begin : g_in
         wcid_debounce #(
            .DEBOUNCE_CYC(DEBOUNCE_CYC)
         ) u_db (
            .clk(clk),
            .srst(srst),
            .pin_n(raw_n[g]),
            .level(clean[g])
         );
      end
   endgenerate

   // either operate input has the same effect
   assign any_operate = clean[`WCID_BIT_ISO_OPER] | clean[`WCID_BIT_SW_OPER];
   assign stop_edge = clean[`WCID_BIT_STOP] & ~stop_prev;

   always @(posedge clk) begin
      if (srst) begin
         operate_prev <= 1'b0;
         stop_prev <= 1'b0;
         operate_start <= 1'b0;
         operate_active <= 1'b0;
         sequence_stop <= 1'b0;
         end_of_weld <= 1'b0;
         thruster_down <= 1'b0;
         hand_probe_present <= 1'b0;
         setup_select <= `WCID_SEL_RESET;
         setup_file <= `WCID_FILE_RESET;
         probe_select <= `WCID_SEL_RESET;
         multi_probe_controller_en <= 1'b0;
         test_key_en <= 1'b0;
         settings_write_en <= 1'b0;
         panel_locked <= 1'b0;
      end else begin
         operate_prev <= any_operate;
         stop_prev <= clean[`WCID_BIT_STOP];
         // rising edge of the merged request starts one sequence
         operate_start <= any_operate & ~operate_prev & ~clean[`WCID_BIT_STOP];
         // a stop held down wins over a new start, so a stuck stop blocks welding
         if (any_operate & ~operate_prev & ~clean[`WCID_BIT_STOP]) begin
            operate_active <= 1'b1;
         end else if (clean[`WCID_BIT_STOP] | ~any_operate) begin
            operate_active <= 1'b0;
         end
         sequence_stop <= stop_edge & ~stop_meaning_jumper;
         end_of_weld <= stop_edge & stop_meaning_jumper;
         // press only if board fitted and no probe controller
         thruster_down <= press_board_fitted & ~multi_probe_controller_fitted
                          & clean[`WCID_BIT_PRESS];
         hand_probe_present <= clean[`WCID_BIT_HPPRES];
         // grounded bit reads one, bit 0 is lsb
         setup_select <= clean[`WCID_BIT_SEL2:`WCID_BIT_SEL0];
         setup_file <= file_of(clean[`WCID_BIT_SEL2:`WCID_BIT_SEL0]);
         // probe controller disabled if a press board is also claimed
         multi_probe_controller_en <= multi_probe_controller_fitted & ~press_board_fitted;
         if (multi_probe_controller_fitted & ~press_board_fitted & probe_selector_ready) begin
            probe_select <= clean[`WCID_BIT_SEL2:`WCID_BIT_SEL0];
         end
         panel_locked <= clean[`WCID_BIT_LOCK];
         test_key_en <= test_key & ~clean[`WCID_BIT_LOCK];
         settings_write_en <= settings_write_req & ~clean[`WCID_BIT_LOCK];
      end
   end
endmodule // wcid_decoder
`default_nettype wire

// file: verilog/wcid_map.vh
// constants for the weld control input decoder
`ifndef WCID_MAP_VH
`define WCID_MAP_VH
`define WCID_CLK_HZ 20000000
`define WCID_DEBOUNCE_US 5000
// 5 ms at 20 MHz, sized to the counter width so the parameter takes it without truncation
`define WCID_DEBOUNCE_CYC 17'h186A0
`define WCID_CNT_W 17
`define WCID_N_IN 9
`define WCID_BIT_ISO_OPER 0
`define WCID_BIT_SW_OPER 1
`define WCID_BIT_STOP 2
`define WCID_BIT_PRESS 3
`define WCID_BIT_HPPRES 4
`define WCID_BIT_SEL0 5
`define WCID_BIT_SEL2 7
`define WCID_BIT_LOCK 8
`define WCID_SEL_RESET 3'h0
`define WCID_FILE_RESET 4'h1
`endif
